// *** design/plw_watchdog.sv ***
// Function
// - Overflow raises internal reset and sets watchdog cause flag bit 4.
// - Clock field: 00 ring, 01 X1, 1x stops watchdog.
// - Period codes select 2^11..2^18 ring or 2^13..2^20 X1 ticks.
// - Reset loads mode register with 67H: ring source, longest period.
// - After reset counting starts at 2^18 ring ticks, no software needed.
// - Mode register takes one write; a second write requests reset.
// - Illegal-access reset waits while the source clock is halted.
// - Top bits written 0,1,1; fixed option ignores other values.
// - Fixed option ignores clock field writes, always ring source.
// - Fixed option never stops; only period changes, once.
// - Once stopped by software, stays stopped and makes no reset.
// - X1 source gated in X1 stop, standby and oscillation wait.
// - Ring source gated in standby, or CPU on X1 with ring off; neither gates it with the fixed option.
// - Mode write inserts a CPU wait cycle, whatever clock the CPU runs from.
// - Writing ACH to restart register clears the counter.
// - Other restart values or bit accesses request internal reset.
// - Restart register always reads 9AH.
// - The legal mode write clears the counter.
`default_nettype none
module plw_watchdog
    import plw_pkg::*;
(
    input  wire logic        sys_clk_i,
    input  wire logic        reset_n_i,
    input  wire logic        fixed_osc_i,
    input  wire logic [15:0] cpu_addr_i,
    input  wire logic [7:0]  cpu_wdata_i,
    input  wire logic        cpu_wr_i,
    input  wire logic        cpu_rd_i,
    input  wire logic        cpu_bit_op_i,
    input  wire logic        ring_tick_i,
    input  wire logic        x1_tick_i,
    input  wire logic        x1_stopped_i,
    input  wire logic        standby_i,
    input  wire logic        osc_wait_i,
    input  wire logic        cpu_on_x1_i,
    input  wire logic        ring_sw_off_i,
    output logic [7:0]       cpu_rdata_o,
    output logic             cpu_wait_o,
    output logic             sys_reset_req_o,
    output logic             dog_reset_cause_flag_o
);
    logic [7:0]         wdog_mode_reg, wdog_mode_next;
    logic               written_reg, written_next;
    logic               stopped_reg, stopped_next;
    logic               fixed_reg, fixed_next;
    logic               armed_reg, armed_next;
    logic               pend_reg, pend_next;
    logic               rst_reg, rst_next;
    logic               cause_reg, cause_next;
    logic [7:0]         rdata_reg, rdata_next;
    logic               wait_reg, wait_next;
    logic               clear;
    logic               src_run;
    logic               tick;
    logic               ovf;
    logic               mode_wr;
    logic               rst_wr;
    logic               illegal;
    logic [PLW_CNT_W:0] limit;

    assign mode_wr = cpu_wr_i && (cpu_addr_i == PLW_MODE_ADDR);
    assign rst_wr  = cpu_wr_i && (cpu_addr_i == PLW_RESTART_ADDR);
    assign limit   = plw_limit(wdog_mode_reg[PLW_PER_MSB:0],
                               wdog_mode_reg[PLW_SRC_BIT]);

    plw_tick_gate u_gate (
        .ring_tick_i   (ring_tick_i),
        .x1_tick_i     (x1_tick_i),
        .src_x1_i      (wdog_mode_reg[PLW_SRC_BIT]),
        .x1_stopped_i  (x1_stopped_i),
        .standby_i     (standby_i && !fixed_reg),
        .osc_wait_i    (osc_wait_i),
        .cpu_on_x1_i   (cpu_on_x1_i),
        .ring_sw_off_i (ring_sw_off_i && !fixed_reg),
        .run_o         (src_run),
        .tick_o        (tick)
    );

    plw_counter u_cnt (
        .sys_clk_i (sys_clk_i),
        .reset_n_i (reset_n_i),
        .clear_i   (clear),
        .tick_i    (tick && !stopped_reg),
        .limit_i   (limit),
        .ovf_o     (ovf)
    );

    // Register writes, illegal-access detection and reset pulse
    always_comb begin
        logic [7:0] wv;
        wv             = cpu_wdata_i;
        wdog_mode_next = wdog_mode_reg;
        written_next   = written_reg;
        stopped_next   = stopped_reg;
        fixed_next     = fixed_reg;
        pend_next      = pend_reg;
        cause_next     = cause_reg;
        rst_next       = 1'b0;
        clear          = 1'b0;
        illegal        = 1'b0;
        // Strap caught on the first edge after release
        armed_next     = 1'b1;
        if (!armed_reg) begin
            fixed_next = fixed_osc_i;
        end
        if (mode_wr) begin
            if (!written_reg) begin
                // Bit operations are not expected here
                if (fixed_reg) begin
                    wv[PLW_STOP_BIT] = 1'b0;
                    wv[PLW_SRC_BIT]  = 1'b0;
                    wv[7:PLW_TOP_LSB] = PLW_FIXED_TOP;
                end
                wdog_mode_next = wv;
                written_next   = 1'b1;
                clear          = 1'b1;
                if (wv[PLW_STOP_BIT]) begin
                    stopped_next = 1'b1;
                end
            end else begin
                illegal = 1'b1;
            end
        end
        if (rst_wr) begin
            if (cpu_wdata_i == PLW_RESTART_KEY && !cpu_bit_op_i) begin
                clear = 1'b1;
            end else begin
                illegal = 1'b1;
            end
        end
        // Stopped dog swallows every reset cause
        if (illegal && !stopped_reg) begin
            pend_next = 1'b1;
        end
        if (pend_next && src_run && !stopped_reg) begin
            rst_next  = 1'b1;
            pend_next = 1'b0;
        end
        if (ovf && !stopped_reg) begin
            rst_next   = 1'b1;
            cause_next = 1'b1;
        end
    end

    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            wdog_mode_reg <= PLW_MODE_RST;
            written_reg   <= 1'b0;
            stopped_reg   <= 1'b0;
            fixed_reg     <= 1'b1;
            armed_reg     <= 1'b0;
            pend_reg      <= 1'b0;
            rst_reg       <= 1'b0;
            cause_reg     <= 1'b0;
        end else begin
            wdog_mode_reg <= wdog_mode_next;
            written_reg   <= written_next;
            stopped_reg   <= stopped_next;
            fixed_reg     <= fixed_next;
            armed_reg     <= armed_next;
            pend_reg      <= pend_next;
            rst_reg       <= rst_next;
            cause_reg     <= cause_next;
        end
    end

    // Read data and write wait, one cycle after the access
    always_comb begin
        rdata_next = 8'h00;
        if (cpu_rd_i && cpu_addr_i == PLW_MODE_ADDR) begin
            rdata_next = wdog_mode_reg;
        end else if (cpu_rd_i && cpu_addr_i == PLW_RESTART_ADDR) begin
            rdata_next = PLW_RESTART_RD;
        end
        wait_next = mode_wr;
    end

    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rdata_reg <= 8'h00;
            wait_reg  <= 1'b0;
        end else begin
            rdata_reg <= rdata_next;
            wait_reg  <= wait_next;
        end
    end

    assign cpu_rdata_o            = rdata_reg;
    assign cpu_wait_o             = wait_reg;
    assign sys_reset_req_o        = rst_reg;
    assign dog_reset_cause_flag_o = cause_reg;

    // Checks

    // Overflow must reach the system reset logic and the cause flag
    AST_OVF_RESET: assert property (@(posedge sys_clk_i)
        disable iff (!reset_n_i) ovf && !stopped_reg |=> rst_reg && cause_reg)
        else $error("overflow without reset");

    // Cause flag is sticky until the next hard reset
    AST_CAUSE_STICKY: assert property (@(posedge sys_clk_i)
        disable iff (!reset_n_i) cause_reg |=> cause_reg)
        else $error("cause flag dropped");

    // Reset logic expects single-cycle requests
    AST_PULSE: assert property (@(posedge sys_clk_i)
        disable iff (!reset_n_i) rst_reg |=> !rst_reg)
        else $error("reset pulse too long");

    // Second mode write is refused and requests reset
    AST_SECOND_WRITE: assert property (@(posedge sys_clk_i)
        disable iff (!reset_n_i)
        mode_wr && written_reg && !stopped_reg && src_run
        |=> rst_reg && $stable(wdog_mode_reg))
        else $error("second mode write not refused");

    // Once written the mode value is frozen
    AST_MODE_ONCE: assert property (@(posedge sys_clk_i)
        disable iff (!reset_n_i) written_reg |=> $stable(wdog_mode_reg))
        else $error("mode changed after write");

    // A stopped dog stays silent
    AST_STOP_QUIET: assert property (@(posedge sys_clk_i)
        disable iff (!reset_n_i) stopped_reg |=> !rst_reg)
        else $error("stopped dog reset");

    // Stop cannot be undone by software
    AST_STOP_STAYS: assert property (@(posedge sys_clk_i)
        disable iff (!reset_n_i) stopped_reg |=> stopped_reg)
        else $error("stopped dog restarted");

    // Fixed option keeps the ring source and never stops
    AST_FIXED_SRC: assert property (@(posedge sys_clk_i)
        disable iff (!reset_n_i) fixed_reg && armed_reg
        |-> !wdog_mode_reg[PLW_SRC_BIT] && !stopped_reg)
        else $error("fixed option left ring");

    // Fixed option keeps the top bits at their pattern
    AST_FIXED_TOP: assert property (@(posedge sys_clk_i)
        disable iff (!reset_n_i) fixed_reg && armed_reg
        |-> wdog_mode_reg[7:PLW_TOP_LSB] == PLW_FIXED_TOP)
        else $error("fixed option top bits");

    // A halted source delivers no ticks
    AST_HALT_NO_TICK: assert property (@(posedge sys_clk_i)
        disable iff (!reset_n_i) !src_run |-> !tick)
        else $error("tick while source halted");

    // Pending reset held back while the source is halted
    AST_PEND_HALT: assert property (@(posedge sys_clk_i)
        disable iff (!reset_n_i) pend_reg && !src_run |=> !rst_reg)
        else $error("reset while source halted");

    // Restart register reads a fixed pattern
    AST_RESTART_RD: assert property (@(posedge sys_clk_i)
        disable iff (!reset_n_i) cpu_rd_i && cpu_addr_i == PLW_RESTART_ADDR
        |=> cpu_rdata_o == PLW_RESTART_RD)
        else $error("restart read value");

    // Wrong restart key requests reset when the source runs
    AST_BAD_KEY: assert property (@(posedge sys_clk_i)
        disable iff (!reset_n_i)
        rst_wr && cpu_wdata_i != PLW_RESTART_KEY && src_run && !stopped_reg
        |=> rst_reg)
        else $error("bad key no reset");

    // Mode write inserts exactly one wait cycle
    AST_WAIT: assert property (@(posedge sys_clk_i)
        disable iff (!reset_n_i) mode_wr |=> cpu_wait_o ##1 !cpu_wait_o
        or mode_wr)
        else $error("mode write wait");

    // No wait without a mode write
    AST_NO_WAIT: assert property (@(posedge sys_clk_i)
        disable iff (!reset_n_i) !mode_wr |=> !cpu_wait_o)
        else $error("spurious wait");

    // Scenarios worth seeing
    COV_OVF: cover property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        ovf ##1 rst_reg);
    COV_KICK: cover property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        rst_wr && cpu_wdata_i == PLW_RESTART_KEY);
    COV_STOP: cover property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        $rose(stopped_reg));
    COV_PEND: cover property (@(posedge sys_clk_i) disable iff (!reset_n_i)
        pend_reg && !src_run ##[1:20] rst_reg);
endmodule
`default_nettype wire

// *** design/plw_pkg.sv ***
`default_nettype none
package plw_pkg;
    // CPU data-space addresses of the two registers
    localparam logic [15:0] PLW_MODE_ADDR    = 16'hFF98;
    localparam logic [15:0] PLW_RESTART_ADDR = 16'hFF99;
    // Reset and fixed values
    localparam logic [7:0]  PLW_MODE_RST     = 8'h67;
    localparam logic [7:0]  PLW_RESTART_RD   = 8'h9A;
    localparam logic [7:0]  PLW_RESTART_KEY  = 8'hAC;
    localparam logic [2:0]  PLW_FIXED_TOP    = 3'h3;
    // Mode register field positions
    localparam int PLW_STOP_BIT   = 4;
    localparam int PLW_SRC_BIT    = 3;
    localparam int PLW_PER_MSB    = 2;
    localparam int PLW_TOP_LSB    = 5;
    // Reset-cause flag position
    localparam int PLW_CAUSE_BIT  = 4;
    // Shortest overflow exponents per source
    localparam int PLW_RING_EXP0  = 11;
    localparam int PLW_X1_EXP0    = 13;
    localparam int PLW_CNT_W      = 20;

    // Overflow length in source ticks for a period code and source
    function automatic logic [PLW_CNT_W:0] plw_limit(
        input logic [2:0] per,
        input logic       src_x1
    );
        int e;
        e = (src_x1 ? PLW_X1_EXP0 : PLW_RING_EXP0) + int'(per);
        plw_limit = (PLW_CNT_W + 1)'(1) << e;
    endfunction
endpackage
`default_nettype wire

// *** design/plw_tick_gate.sv ***
`default_nettype none
// Picks the source tick and gates it off in standby conditions
module plw_tick_gate
    import plw_pkg::*;
(
    input  wire logic ring_tick_i,
    input  wire logic x1_tick_i,
    input  wire logic src_x1_i,
    input  wire logic x1_stopped_i,
    input  wire logic standby_i,
    input  wire logic osc_wait_i,
    input  wire logic cpu_on_x1_i,
    input  wire logic ring_sw_off_i,
    output logic      run_o,
    output logic      tick_o
);
    // Source clock running condition
    always_comb begin
        if (src_x1_i) begin
            run_o = !x1_stopped_i && !standby_i && !osc_wait_i;
        end else begin
            run_o = !standby_i && !(cpu_on_x1_i && ring_sw_off_i);
        end
        tick_o = run_o && (src_x1_i ? x1_tick_i : ring_tick_i);
    end
endmodule
`default_nettype wire

// *** design/plw_counter.sv ***
`default_nettype none
// Free-running up counter with clear and overflow detect
module plw_counter
    import plw_pkg::*;
(
    input  wire logic                 sys_clk_i,
    input  wire logic                 reset_n_i,
    input  wire logic                 clear_i,
    input  wire logic                 tick_i,
    input  wire logic [PLW_CNT_W:0]   limit_i,
    output logic                      ovf_o
);
    logic [PLW_CNT_W:0] cnt_reg;
    logic [PLW_CNT_W:0] cnt_next;

    // Overflow when the next tick would reach the limit
    always_comb begin
        cnt_next = cnt_reg;
        ovf_o    = 1'b0;
        if (clear_i) begin
            cnt_next = '0;
        end else if (tick_i) begin
            if (cnt_reg + 1'b1 >= limit_i) begin
                ovf_o    = 1'b1;
                cnt_next = '0;
            end else begin
                cnt_next = cnt_reg + 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cnt_reg <= '0;
        end else begin
            cnt_reg <= cnt_next;
        end
    end
endmodule
`default_nettype wire

// *** dv/program_loop_watchdog_bench.sv ***
`default_nettype none
module program_loop_watchdog_bench
    import plw_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    logic        sys_clk_i   = 1'b0;
    logic        reset_n     = 1'b0;
    logic        fixed_osc   = 1'b0;
    logic [15:0] cpu_addr    = 16'h0000;
    logic [7:0]  cpu_wdata   = 8'h00;
    logic        cpu_wr      = 1'b0;
    logic        cpu_rd      = 1'b0;
    logic        cpu_bit_op  = 1'b0;
    logic        ring_tick   = 1'b0;
    logic        x1_tick     = 1'b0;
    logic        x1_stopped  = 1'b0;
    logic        standby     = 1'b0;
    logic        osc_wait    = 1'b0;
    logic        cpu_on_x1   = 1'b0;
    logic        ring_sw_off = 1'b0;
    logic [7:0]  cpu_rdata;
    logic        cpu_wait;
    logic        rst_req;
    logic        cause_flag;
    int          error_cnt   = 0;
    int          total_checks = 0;

    plw_watchdog dut_u (
        .sys_clk_i(sys_clk_i), .reset_n_i(reset_n), .fixed_osc_i(fixed_osc),
        .cpu_addr_i(cpu_addr), .cpu_wdata_i(cpu_wdata), .cpu_wr_i(cpu_wr),
        .cpu_rd_i(cpu_rd), .cpu_bit_op_i(cpu_bit_op),
        .ring_tick_i(ring_tick), .x1_tick_i(x1_tick),
        .x1_stopped_i(x1_stopped), .standby_i(standby),
        .osc_wait_i(osc_wait), .cpu_on_x1_i(cpu_on_x1),
        .ring_sw_off_i(ring_sw_off), .cpu_rdata_o(cpu_rdata),
        .cpu_wait_o(cpu_wait), .sys_reset_req_o(rst_req),
        .dog_reset_cause_flag_o(cause_flag)
    );

    // 20 MHz system clock
    always #25 sys_clk_i = ~sys_clk_i;

    task automatic summarize();
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [7:0] seen,
                       input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Strap set before release so the first edge after it samples it
    task automatic do_reset(input logic fixed);
        reset_n    = 1'b0;
        fixed_osc  = fixed;
        ring_tick  = 1'b0;
        x1_tick    = 1'b0;
        x1_stopped = 1'b0;
        standby    = 1'b0;
        osc_wait   = 1'b0;
        cpu_on_x1  = 1'b0;
        ring_sw_off = 1'b0;
        repeat (20) @(posedge sys_clk_i);
        #1 reset_n = 1'b1;
        repeat (2) @(posedge sys_clk_i);
        #1;
    endtask

    // Strobe held one edge, then one idle edge so it never rises twice
    task automatic wr(input logic [15:0] a, input logic [7:0] d,
                      input logic bop, output logic wt, output logic rq);
        cpu_addr   = a;
        cpu_wdata  = d;
        cpu_bit_op = bop;
        cpu_wr     = 1'b1;
        @(posedge sys_clk_i);
        #1;
        wt         = cpu_wait;
        rq         = rst_req;
        cpu_wr     = 1'b0;
        cpu_bit_op = 1'b0;
        @(posedge sys_clk_i);
        #1;
    endtask

    task automatic rd(input logic [15:0] a, output logic [7:0] d);
        cpu_addr = a;
        cpu_rd   = 1'b1;
        @(posedge sys_clk_i);
        #1;
        d        = cpu_rdata;
        cpu_rd   = 1'b0;
        @(posedge sys_clk_i);
        #1;
    endtask

    // Bounded watch for the reset pulse; a missed expected pulse ends the run
    task automatic wait_rst(input int bound, input logic exp, output int n);
        logic hit;
        hit = 1'b0;
        for (n = 0; n < bound && !hit; n++) begin
            if (rst_req === 1'b1) hit = 1'b1;
            else begin
                @(posedge sys_clk_i);
                #1;
            end
        end
        if (exp && !hit) begin
            error_cnt++;
            $display("BAD reset wait expected 1 seen 0");
            summarize();
        end else chk("reset pulse", {7'h00, hit}, {7'h00, exp});
    endtask

    task automatic t_reset_values();
        logic [7:0] d;
        do_reset(1'b0);
        rd(PLW_MODE_ADDR, d);
        chk("mode reset", d, 8'h67);
        rd(PLW_RESTART_ADDR, d);
        chk("restart read", d, 8'h9A);
        rd(16'hFF00, d);
        chk("unmapped read", d, 8'h00);
        chk("cause flag", {7'h00, cause_flag}, 8'h00);
    endtask

    task automatic t_restart();
        logic       w, q;
        logic [7:0] d;
        do_reset(1'b0);
        wr(PLW_RESTART_ADDR, 8'hAC, 1'b0, w, q);
        chk("key write", {7'h00, q}, 8'h00);
        wr(PLW_RESTART_ADDR, 8'hAC, 1'b1, w, q);
        chk("bit op restart", {7'h00, q}, 8'h01);
        wr(PLW_RESTART_ADDR, 8'h55, 1'b0, w, q);
        chk("bad key", {7'h00, q}, 8'h01);
        chk("pulse length", {7'h00, rst_req}, 8'h00);
        rd(PLW_RESTART_ADDR, d);
        chk("restart read", d, 8'h9A);
    endtask

    // Period code 0 on ring: 2048 ticks, restart midway shifts the overflow
    task automatic t_overflow();
        logic w, q;
        int   n;
        do_reset(1'b0);
        ring_tick = 1'b1;
        wr(PLW_MODE_ADDR, 8'h60, 1'b0, w, q);
        chk("mode wait", {7'h00, w}, 8'h01);
        wait_rst(1000, 1'b0, n);
        wr(PLW_RESTART_ADDR, 8'hAC, 1'b0, w, q);
        wait_rst(2100, 1'b1, n);
        chk("overflow len", {7'h00, n >= 2040 && n <= 2056}, 8'h01);
        chk("cause flag", {7'h00, cause_flag}, 8'h01);
        @(posedge sys_clk_i);
        #1;
        chk("pulse length", {7'h00, rst_req}, 8'h00);
    endtask

    task automatic t_second_write();
        logic       w, q;
        logic [7:0] d;
        do_reset(1'b0);
        wr(PLW_MODE_ADDR, 8'h61, 1'b0, w, q);
        chk("first write", {7'h00, q}, 8'h00);
        wr(PLW_MODE_ADDR, 8'h62, 1'b0, w, q);
        chk("second write", {7'h00, q}, 8'h01);
        rd(PLW_MODE_ADDR, d);
        chk("mode kept", d, 8'h61);
    endtask

    // Stopped watchdog ignores every reset cause, including a refused second mode write
    task automatic t_stopped();
        logic w, q;
        int   n;
        do_reset(1'b0);
        ring_tick = 1'b1;
        wr(PLW_MODE_ADDR, 8'h70, 1'b0, w, q);
        wr(PLW_MODE_ADDR, 8'h60, 1'b0, w, q);
        chk("stopped rewrite", {7'h00, q}, 8'h00);
        wr(PLW_RESTART_ADDR, 8'h00, 1'b0, w, q);
        chk("stopped bad key", {7'h00, q}, 8'h00);
        wait_rst(2100, 1'b0, n);
    endtask

    // Fixed option: clock field and top bits forced, ring always counts
    task automatic t_fixed();
        logic       w, q;
        logic [7:0] d;
        int         n;
        do_reset(1'b1);
        ring_tick = 1'b1;
        wr(PLW_MODE_ADDR, 8'h98, 1'b0, w, q);
        rd(PLW_MODE_ADDR, d);
        chk("fixed mode", d, 8'h60);
        // Standby and ring-off must not halt the fixed dog
        standby     = 1'b1;
        ring_sw_off = 1'b1;
        cpu_on_x1   = 1'b1;
        wait_rst(2100, 1'b1, n);
        chk("fixed len", {7'h00, n >= 2040 && n <= 2056}, 8'h01);
    endtask

    // Standby, ring-off and oscillation wait each hold an illegal-key reset until they lift
    task automatic t_gating();
        logic w, q;
        int   n;
        do_reset(1'b0);
        wr(PLW_MODE_ADDR, 8'h60, 1'b0, w, q);
        standby = 1'b1;
        wr(PLW_RESTART_ADDR, 8'h00, 1'b0, w, q);
        chk("standby bad key", {7'h00, q}, 8'h00);
        standby = 1'b0;
        wait_rst(4, 1'b1, n);
        cpu_on_x1   = 1'b1;
        ring_sw_off = 1'b1;
        wr(PLW_RESTART_ADDR, 8'h00, 1'b0, w, q);
        chk("ring off bad key", {7'h00, q}, 8'h00);
        ring_sw_off = 1'b0;
        wait_rst(4, 1'b1, n);
        do_reset(1'b0);
        wr(PLW_MODE_ADDR, 8'h68, 1'b0, w, q);
        osc_wait = 1'b1;
        wr(PLW_RESTART_ADDR, 8'h00, 1'b0, w, q);
        chk("osc wait bad key", {7'h00, q}, 8'h00);
        osc_wait = 1'b0;
        wait_rst(4, 1'b1, n);
    endtask

    // X1 halted: illegal key held pending until the source runs again
    task automatic t_x1_halt();
        logic w, q;
        int   n;
        do_reset(1'b0);
        x1_tick = 1'b1;
        wr(PLW_MODE_ADDR, 8'h68, 1'b0, w, q);
        x1_stopped = 1'b1;
        wr(PLW_RESTART_ADDR, 8'h00, 1'b0, w, q);
        chk("halted bad key", {7'h00, q}, 8'h00);
        wait_rst(8, 1'b0, n);
        x1_stopped = 1'b0;
        wait_rst(4, 1'b1, n);
    endtask

    initial begin
        t_reset_values();
        t_restart();
        t_overflow();
        t_second_write();
        t_stopped();
        t_fixed();
        t_x1_halt();
        t_gating();
        summarize();
    end
endmodule
`default_nettype wire
